// [test/ioxp_expander_tb_top.sv]
/*
  Self-checking bench for the I/O expander: register access over the serial
  bus through the master model, pin checks and alert checks.
  Assumes the package and the expander are compiled before this file.
*/
`timescale 1ns/1ns
module ioxp_expander_tb_top;
  import ioxp_pkg::*;
  // Strap value is arbitrary.
  localparam logic [2:0] STRAP = 3'h5;
  localparam int         LIMIT = 40000;

  logic       sys_clk, link_clk, rst_b, scl, m_sda_oe, sda_oe, alert_oe;
  logic       sda_val, alert_val;
  logic [7:0] ext0, ext1, p0_out, p0_oe, p1_out, p1_oe;
  logic [7:0] rf [8];
  logic [2:0] tb_ptr;
  int         failures, compares, cycles;
  wire logic       sda    = ~(m_sda_oe | (sda_oe & ~sda_val));
  wire logic [7:0] p0_pin = (p0_oe & p0_out) | (~p0_oe & ext0);
  wire logic [7:0] p1_pin = (p1_oe & p1_out) | (~p1_oe & ext1);

  ioxp_master_model mm_u (.clk_in(sys_clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_sda_oe));

  ioxp_expander dut_u (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .link_clk_in(link_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_val), .sda_oe_out(sda_oe),
    .addr_select_bit0_in(STRAP[0]), .addr_select_bit1_in(STRAP[1]),
    .addr_select_bit2_in(STRAP[2]),
    .port_zero_pin_in(p0_pin), .port_zero_pin_out(p0_out), .port_zero_pin_oe_out(p0_oe),
    .port_one_pin_in(p1_pin), .port_one_pin_out(p1_out), .port_one_pin_oe_out(p1_oe),
    .alert_b_out(alert_val), .alert_oe_out(alert_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // The odd offset puts the first link clock rise at 4 ns, on a system clock rise; the two rises meet again every 24 ns.
  initial begin
    link_clk = 1'b0;
    #1;
    forever #3 link_clk = ~link_clk;
  end

  task automatic finish_test();
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Input ports are pin levels through the invert mask; others are stored values.
  function automatic logic [7:0] exp_reg(input logic [2:0] p);
    logic [7:0] pin;
    pin = p[0] ? p1_pin : p0_pin;
    return (p[2:1] == 2'h0) ? (pin ^ rf[{2'h2, p[0]}]) : rf[p];
  endfunction : exp_reg

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic ack;
    mm_u.send_byte(d, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask : send

  task automatic wr3(input logic [2:0] p, input logic [7:0] d0, d1, d2);
    logic [7:0] d [3];
    d = '{d0, d1, d2};
    mm_u.start_cond();
    send({ADDR_PREFIX, STRAP, 1'b0}, 1'b1);
    send({5'h00, p}, 1'b1);
    tb_ptr = p;
    for (int i = 0; i < 3; i++) begin
      send(d[i], 1'b1);
      if (tb_ptr > 3'h1) rf[tb_ptr] = d[i];
      tb_ptr ^= 3'h1;
    end
    mm_u.stop_cond();
    repeat (16) @(posedge sys_clk);
  endtask : wr3

  task automatic rd(input logic cmd, input logic [2:0] p, input int n);
    logic [7:0] d;
    mm_u.start_cond();
    if (cmd) begin
      send({ADDR_PREFIX, STRAP, 1'b0}, 1'b1);
      send({5'h00, p}, 1'b1);
      tb_ptr = p;
      mm_u.start_cond();
    end
    send({ADDR_PREFIX, STRAP, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      mm_u.recv_byte(i == n - 1, d);
      check(d, exp_reg(tb_ptr));
      tb_ptr ^= 3'h1;
    end
    mm_u.stop_cond();
  endtask : rd

  task automatic alert_is(input logic exp);
    int k;
    k = 0;
    while (alert_oe !== exp && k < 40) begin
      @(posedge sys_clk);
      k++;
    end
    check({7'h00, alert_oe}, {7'h00, exp});
  endtask : alert_is

  initial begin
    rst_b    = 1'b0;
    ext0     = 8'h3c;
    ext1     = 8'h96;
    failures = 0;
    compares = 0;
    cycles   = 0;
    tb_ptr   = PTR_RST;
    rf = '{8'h00, 8'h00, OUT_RST, OUT_RST, INV_RST, INV_RST, DIR_RST, DIR_RST};
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check(p0_oe, 8'h00);
    check(p1_oe, 8'h00);
    check({6'h00, sda_val, alert_val}, 8'h00);
    for (int p = 2; p < 8; p += 2) rd(1'b1, p[2:0], 2);
    mm_u.start_cond();
    send({ADDR_PREFIX, ~STRAP, 1'b0}, 1'b0);
    mm_u.stop_cond();
    wr3(3'h3, 8'h5a, 8'ha5, 8'h3c);
    wr3(3'h4, 8'h81, 8'h18, 8'h42);
    wr3(3'h6, 8'h0f, 8'hff, 8'hf0);
    alert_is(1'b0);
    check(p0_oe, ~rf[6]);
    check(p0_out & p0_oe, rf[2] & ~rf[6]);
    check(p1_oe, ~rf[7]);
    wr3(3'h0, 8'h11, 8'h22, 8'h33);
    for (int p = 7; p >= 0; p--) rd(1'b1, p[2:0], 3);
    rd(1'b0, 3'h0, 2);
    ext1 <= ext1 ^ 8'h08;
    alert_is(1'b1);
    ext1 <= ext1 ^ 8'h08;
    alert_is(1'b0);
    ext1 <= ext1 ^ 8'h01;
    alert_is(1'b1);
    rd(1'b1, 3'h1, 1);
    alert_is(1'b0);
    ext1 <= ext1 ^ 8'h40;
    alert_is(1'b1);
    rst_b <= 1'b0;
    repeat (16) @(posedge sys_clk);
    check({7'h00, alert_oe}, 8'h00);
    rst_b <= 1'b1;
    rf = '{8'h00, 8'h00, OUT_RST, OUT_RST, INV_RST, INV_RST, DIR_RST, DIR_RST};
    repeat (10) @(posedge sys_clk);
    check(p0_oe, 8'h00);
    rd(1'b1, 3'h6, 2);
    alert_is(1'b0);
    finish_test();
  end
endmodule : ioxp_expander_tb_top

// [test/ioxp_master_model.sv]
/*
  Serial bus master model for the I/O expander bench: drives the bus clock
  and pulls the data line low through an open-drain enable, one byte at a time.
  Assumes the bench resolves the data wire with a pull-up and feeds it back.
*/
`timescale 1ns/1ns
module ioxp_master_model (
  // Timing reference
  input  wire logic clk_in,
  // Serial bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // Both lines start released, so every transfer begins on an idle bus.
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Eight system cycles keep each bus phase well above the sampling need.
  task automatic half_bit();
    repeat (8) @(posedge clk_in);
  endtask : half_bit

  // Also serves as repeated start: data is released before the clock rises.
  task automatic start_cond();
    @(posedge clk_in);
    sda_oe_out <= 1'b0;
    half_bit();
    scl_out <= 1'b1;
    half_bit();
    sda_oe_out <= 1'b1;
    half_bit();
    scl_out <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    @(posedge clk_in);
    sda_oe_out <= 1'b1;
    half_bit();
    scl_out <= 1'b1;
    half_bit();
    sda_oe_out <= 1'b0;
    half_bit();
  endtask : stop_cond

  // Data moves one cycle after the clock falls, so it never looks like a start or stop.
  task automatic xfer_bit(input logic b, output logic r);
    @(posedge clk_in);
    sda_oe_out <= ~b;
    half_bit();
    scl_out <= 1'b1;
    half_bit();
    r = sda_in;
    scl_out <= 1'b0;
  endtask : xfer_bit

  // The address byte carries the direction in its last bit.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // The last byte of a read is answered with a not-acknowledge.
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
    xfer_bit(last, r);
  endtask : recv_byte
endmodule : ioxp_master_model

// [verilog/ioxp_expander.sv]
/*
  Serial-bus slave that gives a bus master sixteen general purpose pins in
  two ports of eight, with input, output, polarity and direction registers
  reached through a write-only pointer. The serial engine and the register
  file run on link_clk_in, a free-running sampling clock much faster than
  the bus clock; pin drivers and the alert output run on sys_clk_in.
  Assumes SCL and SDA are resolved open-drain wires, and that the pad wire
  of each port pin is fed back on its _in port.
*/
// Overview of operation
// [RULE1] Master starts transfers only on an idle bus.
// [RULE2] Answer address 0100 followed by A2 A1 A0.
// [RULE3] Eighth address bit one reads, zero writes.
// [RULE4] First write byte loads pointer, low three bits.
// [RULE5] Pointer 0..7 selects input, output, invert, direction.
// [RULE6] Pointer is write only and persists.
// [RULE7] Each further write byte goes to pair partner.
// [RULE8] Write bytes unlimited, alternating within the pair.
// [RULE9] Read: write command, repeated start, address read.
// [RULE10] Read returns selected register, then alternates pair.
// [RULE11] Master does not acknowledge the last read byte.
// [RULE12] Later read resumes at partner of last read.
// [RULE13] Pins latched at rising SCL of acknowledge pulse.
// [RULE14] Output pins driven high or low from register.
// [RULE15] Reset: outputs ones, directions ones, invert zeros.
// [RULE16] Input pin edge asserts alert after its delay.
// [RULE17] Alert released on pin return or port read.
// [RULE18] Read clear happens at acknowledge bit rising edge.
// [RULE19] Output pins never alert; switching may alert.
// [RULE20] After clearing, new changes alert again.
// [RULE21] Direction one is input, zero is output.
// [RULE22] Invert bit one inverts stored input level.
// [RULE23] Input registers show pins; writes ignored.
// [RULE24] Output registers read back written value.
// [RULE25] Suffix 0 bit n is port 0 pin n.
`timescale 1ns/1ns
module ioxp_expander
  import ioxp_pkg::*;
(
  // System clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // Link sampling clock
  input  wire logic       link_clk_in,
  // Serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Address select straps
  input  wire logic       addr_select_bit0_in,
  input  wire logic       addr_select_bit1_in,
  input  wire logic       addr_select_bit2_in,
  // Port pins
  input  wire logic [7:0] port_zero_pin_in,
  output logic      [7:0] port_zero_pin_out,
  output logic      [7:0] port_zero_pin_oe_out,
  input  wire logic [7:0] port_one_pin_in,
  output logic      [7:0] port_one_pin_out,
  output logic      [7:0] port_one_pin_oe_out,
  // Open-drain alert
  output logic            alert_b_out,
  output logic            alert_oe_out
);

  // Link domain reset and input synchronisers.
  logic              link_rst_meta;
  logic              link_rst_b;
  logic              scl_meta, scl_s, scl_d;
  logic              sda_meta, sda_s, sda_d;
  logic [15:0]       pins_meta, pins_s;
  logic [2:0]        asel_meta, asel_s;
  logic              scl_rise, scl_fall, start_det, stop_det;
  // Serial engine.
  ioxp_state_t       state;
  logic [3:0]        bit_cnt;
  logic [7:0]        rx;
  logic [7:0]        tx;
  logic              is_read, cmd_pend, ackd;
  logic [PTR_W-1:0]  ptr, sent_sel;
  logic              wr_evt, rd_load;
  // Register file.
  logic [7:0]        out_port [2];
  logic [7:0]        inv_port [2];
  logic [7:0]        dir_port [2];
  logic [15:0]       snap;
  logic              snap_init;
  logic              alert_pend;
  ioxp_cfg_t         cfg_link;
  logic              cfg_tgl;
  // System domain.
  logic              tgl_meta, tgl_s, tgl_d;
  ioxp_cfg_t         cfg_sys;
  logic              al_meta, al_s;
  logic [7:0]        drv_out [2];
  logic [7:0]        drv_oe  [2];

  // The reset level is re-timed so the link logic leaves reset cleanly.
  always_ff @(posedge link_clk_in) begin
    link_rst_meta <= rst_b_in;
    link_rst_b    <= link_rst_meta;
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      scl_meta  <= 1'b1;
      scl_s     <= 1'b1;
      scl_d     <= 1'b1;
      sda_meta  <= 1'b1;
      sda_s     <= 1'b1;
      sda_d     <= 1'b1;
      asel_meta <= 3'h0;
      asel_s    <= 3'h0;
    end else begin
      scl_meta  <= scl_in;
      scl_s     <= scl_meta;
      scl_d     <= scl_s;
      sda_meta  <= sda_in;
      sda_s     <= sda_meta;
      sda_d     <= sda_s;
      asel_meta <= {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in};
      asel_s    <= asel_meta;
    end
  end

  // Pin levels are synchronised without reset, so the snapshot taken on the
  // first cycle after reset holds real levels and raises no false alert.
  always_ff @(posedge link_clk_in) begin
    pins_meta <= {port_one_pin_in, port_zero_pin_in}; // [RULE25]
    pins_s    <= pins_meta;
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  assign wr_evt  = (state == ST_WBYTE) && scl_fall && (bit_cnt == BITS_PER_BYTE);
  // Next byte is taken at the rising edge of the acknowledge pulse. [RULE13]
  assign rd_load = scl_rise && (((state == ST_ADDR_ACK) && is_read) ||
                                ((state == ST_RACK) && !sda_s));

  // Input registers are live pins through the invert mask. [RULE22] [RULE23]
  function automatic logic [7:0] reg_value(input logic [PTR_W-1:0] sel);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      REG_IN0:  v = pins_s[7:0] ^ inv_port[0];
      REG_IN1:  v = pins_s[15:8] ^ inv_port[1];
      REG_OUT0: v = out_port[0]; // [RULE24]
      REG_OUT1: v = out_port[1];
      REG_INV0: v = inv_port[0];
      REG_INV1: v = inv_port[1];
      REG_DIR0: v = dir_port[0];
      default:  v = dir_port[1];
    endcase
    return v;
  endfunction : reg_value

  // Serial engine; START and STOP win over any bit in progress.
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      state      <= ST_IDLE; // [RULE15]
      bit_cnt    <= 4'h0;
      rx         <= 8'h00;
      is_read    <= 1'b0;
      cmd_pend   <= 1'b0;
      ackd       <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_det) begin
      state      <= ST_ADDR;
      bit_cnt    <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_det) begin
      state      <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            rx      <= {rx[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            if (state == ST_WBYTE) begin
              cmd_pend   <= 1'b0;
              sda_oe_out <= 1'b1;
              state      <= ST_WACK; // [RULE8]
            end else if (rx[7:1] == {ADDR_PREFIX, asel_s}) begin // [RULE2]
              is_read    <= rx[0]; // [RULE3]
              cmd_pend   <= ~rx[0];
              sda_oe_out <= 1'b1;
              state      <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (is_read) begin
              sda_oe_out <= ~tx[7];
              state      <= ST_RBYTE;
            end else begin
              sda_oe_out <= 1'b0;
              state      <= ST_WBYTE;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            state      <= ST_WBYTE;
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            if (bit_cnt == LAST_TX_BIT) begin
              sda_oe_out <= 1'b0;
              state      <= ST_RACK;
            end else begin
              bit_cnt    <= bit_cnt + 4'h1;
              sda_oe_out <= ~tx[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ackd <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (ackd) begin
              sda_oe_out <= ~tx[7];
              state      <= ST_RBYTE; // [RULE10]
            end else begin
              state <= ST_IDLE; // [RULE11]
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    sda_out <= 1'b0;
  end

  // The pointer survives between transfers and is never returned. [RULE6]
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      ptr <= PTR_RST;
    end else if (wr_evt && cmd_pend) begin
      ptr <= rx[PTR_W-1:0]; // [RULE4] [RULE5]
    end else if (wr_evt || rd_load) begin
      ptr <= ptr ^ 3'h1; // [RULE7] [RULE10] [RULE12]
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      tx       <= 8'h00;
      sent_sel <= PTR_RST;
    end else if (rd_load) begin
      tx       <= reg_value(ptr); // [RULE13]
      sent_sel <= ptr;
    end else if (state == ST_RBYTE && scl_fall) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // Writable registers; writes to the input pair only move the pointer.
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      out_port[0] <= OUT_RST; // [RULE15]
      out_port[1] <= OUT_RST;
      inv_port[0] <= INV_RST;
      inv_port[1] <= INV_RST;
      dir_port[0] <= DIR_RST;
      dir_port[1] <= DIR_RST;
      cfg_tgl     <= 1'b0;
    end else if (wr_evt && !cmd_pend) begin
      case (ptr)
        REG_OUT0: out_port[0] <= rx;
        REG_OUT1: out_port[1] <= rx;
        REG_INV0: inv_port[0] <= rx;
        REG_INV1: inv_port[1] <= rx;
        REG_DIR0: dir_port[0] <= rx;
        REG_DIR1: dir_port[1] <= rx;
        default:  out_port[0] <= out_port[0]; // [RULE23]
      endcase
      cfg_tgl <= ~cfg_tgl;
    end
  end

  assign cfg_link.out = {out_port[1], out_port[0]};
  assign cfg_link.dir = {dir_port[1], dir_port[0]};

  // Snapshot of pin levels last reported; a read of a port refreshes it.
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      snap_init <= 1'b1;
    end else begin
      snap_init <= 1'b0;
    end
  end

  generate
    for (genvar p = 0; p < 2; p++) begin : g_snap
      always_ff @(posedge link_clk_in) begin
        if (!link_rst_b) begin
          snap[p*PORT_W +: PORT_W] <= 8'h00;
        end else if (snap_init) begin
          snap[p*PORT_W +: PORT_W] <= pins_s[p*PORT_W +: PORT_W];
        end else if (state == ST_RACK && scl_rise &&
                     sent_sel == (p == 0 ? REG_IN0 : REG_IN1)) begin
          snap[p*PORT_W +: PORT_W] <= pins_s[p*PORT_W +: PORT_W]; // [RULE17] [RULE18]
        end
      end
    end
  endgenerate

  // A level compare rather than an edge latch, so a pin that returns to
  // its old level drops the alert without any read.
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b || snap_init) begin
      alert_pend <= 1'b0;
    end else begin
      alert_pend <= |((pins_s ^ snap) & cfg_link.dir); // [RULE16] [RULE19] [RULE20]
    end
  end

  // Configuration crossing: the word is held for at least one serial byte
  // after each toggle, far longer than the three-stage toggle path.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      tgl_meta <= 1'b0;
      tgl_s    <= 1'b0;
      tgl_d    <= 1'b0;
      cfg_sys  <= '{out: {OUT_RST, OUT_RST}, dir: {DIR_RST, DIR_RST}};
    end else begin
      tgl_meta <= cfg_tgl;
      tgl_s    <= tgl_meta;
      tgl_d    <= tgl_s;
      if (tgl_s ^ tgl_d) begin
        cfg_sys <= cfg_link;
      end
    end
  end

  generate
    for (genvar p = 0; p < 2; p++) begin : g_drive
      always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
          drv_out[p] <= OUT_RST;
          drv_oe[p]  <= 8'h00;
        end else begin
          drv_out[p] <= cfg_sys.out[p*PORT_W +: PORT_W]; // [RULE14] [RULE24]
          drv_oe[p]  <= ~cfg_sys.dir[p*PORT_W +: PORT_W]; // [RULE21]
        end
      end
    end
  endgenerate

  assign port_zero_pin_out    = drv_out[0];
  assign port_zero_pin_oe_out = drv_oe[0];
  assign port_one_pin_out     = drv_out[1];
  assign port_one_pin_oe_out  = drv_oe[1];

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      al_meta      <= 1'b0;
      al_s         <= 1'b0;
      alert_oe_out <= 1'b0;
      alert_b_out  <= 1'b0;
    end else begin
      al_meta      <= alert_pend;
      al_s         <= al_meta;
      alert_oe_out <= al_s; // [RULE16]
      alert_b_out  <= 1'b0;
    end
  end

  a_addr_match: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE2]
    $rose(state == ST_ADDR_ACK) |-> $past(rx[7:1]) == {ADDR_PREFIX, asel_s})
    else $error("Acknowledged an address that is not ours.");

  a_ptr_from_cmd: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE4]
    (wr_evt && cmd_pend) |=> ptr == $past(rx[2:0]))
    else $error("Command byte did not load the pointer.");

  a_write_toggle: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE7]
    (wr_evt && !cmd_pend) |=> (ptr[0] != $past(ptr[0])) && (ptr[2:1] == $past(ptr[2:1])))
    else $error("Write did not move to the pair partner.");

  a_read_toggle: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE10]
    rd_load |=> (ptr == ($past(ptr) ^ 3'h1)) && (tx == reg_value($past(ptr))))
    else $error("Read did not load the selected register and alternate.");

  a_read_clears: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE18]
    (state == ST_RACK && scl_rise && sent_sel == REG_IN0)
    |=> snap[7:0] == $past(pins_s[7:0]))
    else $error("Port read did not refresh its snapshot.");

  a_alert_sets: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE16]
    (!snap_init && |((pins_s ^ snap) & cfg_link.dir)) |=> alert_pend)
    else $error("Input change did not raise the alert.");

  a_output_quiet: assert property (@(posedge link_clk_in) disable iff (!link_rst_b) // [RULE19]
    $stable(pins_s & cfg_link.dir) && $stable(cfg_link.dir) && !alert_pend |=> !alert_pend)
    else $error("Output pins raised the alert.");

  a_alert_pin: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [RULE16]
    $rose(al_meta) |-> ##2 alert_oe_out)
    else $error("Alert did not reach the pin in two cycles.");

  a_reset_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [RULE15]
    $rose(rst_b_in) |-> (port_zero_pin_oe_out == 8'h00) && (port_one_pin_oe_out == 8'h00))
    else $error("Pins driven right after reset.");

  a_pin_drive: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in) // [RULE14]
    (tgl_s ^ tgl_d) ##1 (tgl_s == tgl_d)[*2]
    |-> port_zero_pin_oe_out == ~cfg_sys.dir[7:0] && port_zero_pin_out == cfg_sys.out[7:0])
    else $error("Port 0 drivers do not follow the configuration.");

  c_write: cover property (@(posedge link_clk_in) disable iff (!link_rst_b)
    wr_evt && !cmd_pend);
  c_read_two: cover property (@(posedge link_clk_in) disable iff (!link_rst_b)
    rd_load && state == ST_RACK);
  c_alert: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(alert_oe_out));

endmodule : ioxp_expander

// [verilog/ioxp_pkg.sv]
/*
  Shared definitions for the sixteen-pin serial I/O expander: register
  selector codes, reset values, slave address prefix, serial engine states
  and the configuration word that crosses from the link to the pin domain.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package ioxp_pkg;

  // Register selector codes carried in the low three bits of the command byte.
  localparam logic [2:0] REG_IN0  = 3'h0;
  localparam logic [2:0] REG_IN1  = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_INV0 = 3'h4;
  localparam logic [2:0] REG_INV1 = 3'h5;
  localparam logic [2:0] REG_DIR0 = 3'h6;
  localparam logic [2:0] REG_DIR1 = 3'h7;
  localparam logic [2:0] PTR_RST  = 3'h0;

  // Reset values of the writable registers.
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] INV_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;

  // Fixed upper four bits of the seven-bit slave address.
  localparam logic [3:0] ADDR_PREFIX = 4'h4;

  // Field layout of the command byte and of a serial byte.
  localparam int PTR_W      = 3;
  localparam int PORT_W     = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  // Serial engine states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WBYTE    = 7'h08,
    ST_WACK     = 7'h10,
    ST_RBYTE    = 7'h20,
    ST_RACK     = 7'h40
  } ioxp_state_t;

  // Pin-facing configuration: bit n of the low byte is port 0 pin n.
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] dir;
  } ioxp_cfg_t;

endpackage : ioxp_pkg
